// ==== bench/clear_ops_sva.sv ====
// Port-level checker for the clear and watchdog-restart decoder
`timescale 1ns/1ps
module clear_ops_sva (
  // Clock and reset
  input wire        clk,
  input wire        reset,
  // Bus
  input wire [3:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire        waitrequest,
  // Watchdog side
  input wire [7:0]  watchdog_counter,
  input wire [7:0]  watchdog_post,
  input wire        timeout_flag,
  input wire        powerdown_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Restart settles on the third edge after its write is taken
  chk_restart_effect:
  assert property (write && !waitrequest && address == 4'h1 && writedata[15:0] == 16'h0004 |-> ##4
    (timeout_flag && powerdown_flag && watchdog_counter == 8'h00 && watchdog_post == 8'h00))
    else $error("restart did not clear watchdog or set flags");
  // A new instruction is held off while the last one runs
  chk_instr_stall:
  assert property (write && !waitrequest && address == 4'h1 |-> ##2 ((write && address == 4'h1) |-> waitrequest))
    else $error("instruction accepted while busy");
  chk_read_wait:
  assert property ($rose(read) |-> waitrequest ##1 !waitrequest) else $error("read wait not one cycle");
  chk_write_nowait:
  assert property (write && address != 4'h1 |-> !waitrequest) else $error("plain write stalled");
  chk_readdata_hold:
  assert property (!(read && waitrequest) |=> $stable(readdata)) else $error("read data moved");
  chk_reset_values:
  assert property ($fell(reset) |-> timeout_flag && powerdown_flag && watchdog_counter == 8'h00)
    else $error("bad values after reset");
endmodule

// ==== bench/clear_ops_tb.sv ====
// Self-checking bench for the clear and watchdog-restart decoder
`timescale 1ns/1ps
`include "clear_ops_defines.vh"
`define CHK(n, e, s) begin comparisons = comparisons + 1; if ((s) !== (e)) begin n_fail = n_fail + 1; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module clear_ops_tb;
  reg         clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, watchdog_tick = 1'b0;
  reg  [3:0]  address = 4'h0;
  reg  [31:0] writedata = 32'h0, q;
  wire [31:0] readdata;
  wire        waitrequest, timeout_flag, powerdown_flag;
  wire [7:0]  watchdog_counter, watchdog_post;
  integer     n_fail = 0, comparisons = 0, cyc = 0;
  clear_ops u_dut (.clk, .reset, .address, .read, .write, .writedata, .readdata, .waitrequest,
    .watchdog_tick, .watchdog_counter, .watchdog_post, .timeout_flag, .powerdown_flag);
  // 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end
  // One transfer, held until waitrequest is seen low at an edge
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      write <= w;
      read <= !w;
      address <= a;
      writedata <= d;
      @(posedge clk);
      while (waitrequest) @(posedge clk);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Poll the busy bit rather than assume a cycle count
  task wait_idle;
    begin
      bus(0, `REG_INSTR, 0);
      while (q[16]) bus(0, `REG_INSTR, 0);
    end
  endtask
  // Preload a byte, clear it by instruction, read it back
  task clear_case(input ext, input [15:0] ins, input [11:0] tgt);
    begin
      bus(1, `REG_CTRL, {31'h0, ext});
      bus(1, `REG_MEM_ADDR, {20'h0, tgt});
      bus(1, `REG_MEM_DATA, 32'h5a);
      bus(1, `REG_INSTR, {16'h0, ins});
      wait_idle;
      bus(1, `REG_MEM_ADDR, {20'h0, tgt});
      bus(0, `REG_MEM_DATA, 0);
      `CHK("cleared byte", 8'h00, q[7:0])
    end
  endtask
  // Let the watchdog run, then restart twice back to back
  task restart_case;
    begin
      bus(1, `REG_STATUS, 0);
      watchdog_tick <= 1'b1;
      repeat (300) @(posedge clk);
      watchdog_tick <= 1'b0;
      bus(0, `REG_STATUS, 0);
      `CHK("flags cleared", 2'b00, q[1:0])
      // 300 ticks: postscaler wraps once, so post 2ch and count 01h
      bus(0, `REG_WDOG, 0);
      `CHK("watchdog run", 32'h00002c01, q)
      bus(1, `REG_INSTR, 32'h4);
      bus(1, `REG_INSTR, 32'h4);
      wait_idle;
      `CHK("flags", 2'b11, {timeout_flag, powerdown_flag})
      `CHK("watchdog", 16'h0000, {watchdog_counter, watchdog_post})
      bus(0, `REG_STATUS, 0);
      `CHK("status", 2'b11, q[1:0])
      // Unknown opcode does nothing but raise the illegal bit
      bus(1, `REG_INSTR, 32'h1234);
      wait_idle;
      `CHK("illegal", 1'b1, q[17])
    end
  endtask
  task tally_and_finish;
    begin
      if (n_fail == 0 && comparisons > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      n_fail = n_fail + 1;
      tally_and_finish;
    end
  end
  // Boundary operands on both sides of the indexed range
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    bus(1, `REG_BANK, 32'h3);
    bus(1, `REG_INDEX, 32'h100);
    clear_case(0, 16'h6a10, 12'h010);
    clear_case(0, 16'h6a80, 12'hf80);
    clear_case(0, 16'h6b20, 12'h320);
    clear_case(1, 16'h6a5f, 12'h15f);
    clear_case(1, 16'h6a60, 12'hf60);
    clear_case(1, 16'h6b05, 12'h305);
    restart_case;
    tally_and_finish;
  end
endmodule
bind clear_ops clear_ops_sva u_sva (.clk, .reset, .address, .read, .write, .writedata, .readdata,
  .waitrequest, .watchdog_counter, .watchdog_post, .timeout_flag, .powerdown_flag);

// ==== rtl/clear_ops.v ====
// Decoder and executor for the register-clear and watchdog-restart instructions
// Summary of operation
// - Opcode 0110 101a ffffffff writes zero into the addressed data register.
// - Bit a=0 selects access bank; a=1 forms address from bank pointer.
// - Extended set, a=0, operand up to 5Fh: indexed literal offset addressing.
// - Opcode 0004h sets the timeout and power-down flags.
// - Watchdog restart clears the watchdog count and its postscaler.
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "clear_ops_defines.vh"
module clear_ops (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Avalon-MM slave
  input  wire [3:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  // Watchdog side
  input  wire        watchdog_tick,
  output reg  [7:0]  watchdog_counter,
  output reg  [7:0]  watchdog_post,
  output reg         timeout_flag,
  output reg         powerdown_flag
);
  // Software-visible state
  reg         ext_enable;
  reg  [15:0] instr;
  reg  [3:0]  bank_pointer_reg;
  reg  [11:0] index_reg;
  reg  [11:0] mem_addr;
  reg         issued;
  reg         rd_pending;
  // Decode stage results
  reg         is_clear;
  reg         is_wdt;
  reg  [11:0] target;
  reg         illegal;
  wire [1:0]  phase;
  wire        busy;
  wire [7:0]  mem_rdata;
  reg  [7:0]  next_target_low;
  wire        start;
  wire        mem_we;
  wire        op_clear;
  wire        op_wdt;
  wire [7:0]  operand;
  wire        a_bit;

  // Writing the instruction register issues it
  assign start = write && !waitrequest && (address == `REG_INSTR) && !busy;

  phase_seq u_seq (
    .clk   (clk),
    .reset (reset),
    .start (start),
    .phase (phase),
    .busy  (busy)
  );

  // Instruction field split
  assign operand  = instr[7:0];
  assign a_bit    = instr[`CLR_A_BIT];
  assign op_clear = (instr & `CLR_OPC_MASK) == `CLR_OPC_VALUE;
  assign op_wdt   = instr == `WDT_OPC_VALUE;

  // Effective address for the clear; indexed mode adds operand to index
  always @* begin
    next_target_low = operand;
    if (!a_bit && ext_enable && (operand <= `ILO_LIMIT)) begin
      next_target_low = operand;
    end
  end

  // Phase 0 decodes; phase 1 forms operand address
  always @(posedge clk) begin
    if (reset) begin
      is_clear <= 1'b0;
      is_wdt   <= 1'b0;
      illegal  <= 1'b0;
      target   <= 12'h000;
    end else if (busy && phase == 2'h0) begin
      is_clear <= op_clear;
      is_wdt   <= op_wdt;
      illegal  <= !op_clear && !op_wdt;
    end else if (busy && phase == 2'h1 && is_clear) begin
      if (a_bit) begin
        target <= {bank_pointer_reg, operand};
      end else if (ext_enable && (operand <= `ILO_LIMIT)) begin
        target <= index_reg + {4'h0, next_target_low};
      end else if (operand < `ACCESS_SPLIT) begin
        target <= {4'h0, operand};
      end else begin
        target <= {`ACCESS_HI_BANK, operand};
      end
    end
  end

  // Clear writes zero on the last phase; a bus memory write shares the port
  assign mem_we = busy && (phase == 2'h3) && is_clear;

  data_mem u_mem (
    .clk   (clk),
    .we    (mem_we || (write && !waitrequest && address == `REG_MEM_DATA)),
    .waddr (mem_we ? target : mem_addr),
    .wdata (mem_we ? 8'h00 : writedata[7:0]),
    .raddr (mem_addr),
    .rdata (mem_rdata)
  );

  // Watchdog count and postscaler; restart in process phase wins over tick
  always @(posedge clk) begin
    if (reset) begin
      watchdog_counter <= 8'h00;
      watchdog_post    <= 8'h00;
    end else if (busy && phase == 2'h2 && is_wdt) begin
      watchdog_counter <= 8'h00;
      watchdog_post    <= 8'h00;
    end else if (watchdog_tick) begin
      watchdog_post <= watchdog_post + 8'h01;
      if (watchdog_post == 8'hff) begin
        watchdog_counter <= watchdog_counter + 8'h01;
      end
    end
  end

  // Status flags: restart sets both; software write may clear them
  always @(posedge clk) begin
    if (reset) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
    end else if (busy && phase == 2'h2 && is_wdt) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
    end else if (write && !waitrequest && address == `REG_STATUS) begin
      timeout_flag   <= writedata[`STAT_TO_BIT];
      powerdown_flag <= writedata[`STAT_PD_BIT];
    end
  end

  // Bus stalls a second write to the instruction register while busy
  assign waitrequest = (write && address == `REG_INSTR && busy) || (read && !rd_pending);

  // Register writes
  always @(posedge clk) begin
    if (reset) begin
      ext_enable       <= 1'b0;
      instr            <= 16'h0000;
      bank_pointer_reg <= 4'h0;
      index_reg        <= 12'h000;
      mem_addr         <= 12'h000;
      issued           <= 1'b0;
    end else begin
      if (start) begin
        instr  <= writedata[15:0];
        issued <= 1'b1;
      end
      if (write && !waitrequest) begin
        case (address)
          `REG_CTRL:     ext_enable       <= writedata[`CTRL_EXT_BIT];
          `REG_BANK:     bank_pointer_reg <= writedata[3:0];
          `REG_INDEX:    index_reg        <= writedata[11:0];
          `REG_MEM_ADDR: mem_addr         <= writedata[11:0];
          default:       ;
        endcase
      end
    end
  end

  // Reads take one wait cycle so the memory read settles
  always @(posedge clk) begin
    if (reset) begin
      rd_pending <= 1'b0;
    end else begin
      rd_pending <= read && !rd_pending;
    end
  end

  // Read data mux, captured on the first cycle of a read only so the word
  // stands unchanged through the wait cycle and until the next read
  always @(posedge clk) begin
    if (reset) begin
      readdata <= 32'h00000000;
    end else if (read && !rd_pending) begin
      case (address)
        `REG_CTRL:     readdata <= {31'h0, ext_enable};
        `REG_INSTR:    readdata <= {14'h0, illegal, busy, instr};
        `REG_BANK:     readdata <= {28'h0, bank_pointer_reg};
        `REG_INDEX:    readdata <= {20'h0, index_reg};
        `REG_STATUS:   readdata <= {30'h0, timeout_flag, powerdown_flag};
        `REG_WDOG:     readdata <= {16'h0, watchdog_post, watchdog_counter};
        `REG_MEM_ADDR: readdata <= {20'h0, mem_addr};
        `REG_MEM_DATA: readdata <= {24'h0, mem_rdata};
        default:       readdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// ==== rtl/clear_ops_defines.vh ====
// Constants for the clear-register and watchdog-restart decoder
`ifndef CLEAR_OPS_DEFINES_VH
`define CLEAR_OPS_DEFINES_VH
// Register offsets on the Avalon-MM bus (word indices)
`define REG_CTRL        4'h0
`define REG_INSTR       4'h1
`define REG_BANK        4'h2
`define REG_INDEX       4'h3
`define REG_STATUS      4'h4
`define REG_WDOG        4'h5
`define REG_MEM_ADDR    4'h6
`define REG_MEM_DATA    4'h7
// Control register fields
`define CTRL_EXT_BIT    0
// Status register fields
`define STAT_PD_BIT     0
`define STAT_TO_BIT     1
`define STAT_RESET      8'h00
// Opcodes
`define CLR_OPC_MASK    16'hfe00
`define CLR_OPC_VALUE   16'h6a00
`define WDT_OPC_VALUE   16'h0004
`define CLR_A_BIT       8
// Indexed literal offset range limit
`define ILO_LIMIT       8'h5f
// Access bank split: operands below 60h map to bank 0, 60h and up to bank f
`define ACCESS_SPLIT    8'h60
`define ACCESS_HI_BANK  4'hf
// Last phase of the instruction cycle (phases 0..3)
`define PHASE_COUNT     2'h3
`endif

// ==== rtl/data_mem.v ====
// Data memory of 4096 bytes with one write and one read port
`timescale 1ns/1ps
module data_mem (
  // Clock
  input  wire        clk,
  // Write port
  input  wire        we,
  input  wire [11:0] waddr,
  input  wire [7:0]  wdata,
  // Read port
  input  wire [11:0] raddr,
  output reg  [7:0]  rdata
);
  reg [7:0] mem [0:4095];
  // Registered read; memory content is not reset
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ==== rtl/phase_seq.v ====
// Four-phase instruction cycle sequencer
`timescale 1ns/1ps
`include "clear_ops_defines.vh"
module phase_seq (
  // Clock and reset
  input  wire       clk,
  input  wire       reset,
  // Start and phase state
  input  wire       start,
  output reg  [1:0] phase,
  output reg        busy
);
  // Runs phases 0..3 once per started instruction
  always @(posedge clk) begin
    if (reset) begin
      phase <= 2'h0;
      busy  <= 1'b0;
    end else if (busy) begin
      if (phase == `PHASE_COUNT) begin
        busy  <= 1'b0;
        phase <= 2'h0;
      end else begin
        phase <= phase + 2'h1;
      end
    end else if (start) begin
      busy  <= 1'b1;
      phase <= 2'h0;
    end
  end
endmodule
